// *** asp_pkg.sv ***
// asp_pkg: shared constants for the asynchronous serial port block
// assumes a single core clock; mode, timer and register values come from a plain register port
`default_nettype none
package asp_pkg;
	// register port offsets
	localparam logic [3:0] ADDR_SCON0   = 4'h0; // port 0 control/status
	localparam logic [3:0] ADDR_SERIAL_BUFFER_PORT0   = 4'h1; // port 0 serial buffer
	localparam logic [3:0] ADDR_SCON1   = 4'h2; // port 1 control/status
	localparam logic [3:0] ADDR_SERIAL_BUFFER_PORT1   = 4'h3; // port 1 serial buffer
	localparam logic [3:0] ADDR_T2CTL   = 4'h4; // timer 2 control
	localparam logic [3:0] ADDR_RCAPL   = 4'h5; // timer 2 reload low
	localparam logic [3:0] ADDR_RCAPH   = 4'h6; // timer 2 reload high
	localparam logic [3:0] ADDR_MISC    = 4'h7; // baud double bits
	// control field positions (scon)
	localparam int B_MODE_HI = 7; // mode bits 7:6
	localparam int B_MPE     = 5; // multiprocessor enable
	localparam int B_REN     = 4; // receive enable
	localparam int B_TB8     = 3; // transmit ninth bit
	localparam int B_RB8     = 2; // received ninth bit
	localparam int B_TI      = 1; // transmit done
	localparam int B_RI      = 0; // receive done
	// timer 2 control bit positions
	localparam int B_TF2     = 7; // overflow flag
	localparam int B_RCLK    = 5; // rx from timer 2
	localparam int B_TX_BAUD_FROM_TIMER2    = 4; // tx from timer 2
	localparam int B_EXEN    = 3; // external reload enable
	localparam int B_TR2     = 2; // timer run
	// reset values
	localparam logic [7:0]  SCON_RST  = 8'h00;
	localparam logic [15:0] T2_RST    = 16'h0000;
	// timing counts
	localparam logic [3:0] DIV16_LAST = 4'hf; // divide-by-16 rollover
	localparam logic [3:0] SAMP_A     = 4'h7; // majority samples 7,8,9
	localparam logic [3:0] SAMP_C     = 4'h9;
	localparam logic [5:0] M2_DIV64   = 6'h03; // prescaler value at each 1/16-bit tick, /64 baud
	localparam logic [1:0] TI_DELAY   = 2'h2; // mode 1 done delay
	localparam logic [3:0] BITS_M1    = 4'h9; // bits after start, mode 1
	localparam logic [3:0] BITS_M23   = 4'ha; // bits after start, modes 2/3
	// transmit/receive states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_SHIFT = 2'b10,
		ST_DONE  = 2'b11
	} asp_state_t;
endpackage : asp_pkg
`default_nettype wire

// *** asp_top.sv ***
// asp_top: two serial ports in modes 1-3; timer 2 baud generator for port 0 only
// assumes timer 1 overflow arrives as a one-cycle pulse; pins synchronous to clk
`default_nettype none
module asp_top
	import asp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	input  wire logic       timer1_overflow,
	input  wire logic       timer2_external_reload_trigger,
	input  wire logic       receive_pin_port0,
	input  wire logic       receive_pin_port1,
	output var  logic       transmit_pin_port0,
	output var  logic       transmit_pin_port1
);
	import asp_pkg::*;

	logic [7:0]  timer2_control_reg;   // timer 2 control
	logic [7:0]  reload_capture_low;   // reload low byte
	logic [7:0]  reload_capture_high;  // reload high byte
	logic [15:0] t2_count;             // timer 2 counter
	logic [1:0]  baud_double_select;   // per-port baud double
	logic [5:0]  m2_div;               // mode 2 prescaler
	logic [7:0]  scon_rd [2];          // status view per port
	logic [7:0]  sbuf_rd [2];          // received byte per port
	logic        t2_baud;              // timer 2 in baud use
	logic        t2_half;              // divide-by-2 phase for baud use

	// timer 2 overflow and baud use; in baud use it counts every other clock
	wire t2_step   = !t2_baud || t2_half;
	wire t2_roll   = timer2_control_reg[B_TR2] && (t2_count == 16'hffff) && t2_step;
	wire tx_baud_from_timer2      = timer2_control_reg[B_TX_BAUD_FROM_TIMER2];
	wire rclk      = timer2_control_reg[B_RCLK];
	assign t2_baud = tx_baud_from_timer2 | rclk;
	wire ext_reload = timer2_control_reg[B_EXEN] && timer2_external_reload_trigger && !t2_baud;
	wire m2_tick_full = (m2_div[1:0] == M2_DIV64[1:0]);
	wire m2_tick_half = (m2_div[0] == M2_DIV64[0]);
	wire wr_t2 = wr && (addr == ADDR_T2CTL);
	// starting the timer loads the reload value so the first overflow is not a full wrap away
	wire t2_start = wr_t2 && wdata[B_TR2] && !timer2_control_reg[B_TR2];

	// timer 2 counter with auto-reload
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			t2_count <= T2_RST;
		end else if (t2_start || t2_roll || ext_reload) begin
			t2_count <= {reload_capture_high, reload_capture_low};
		end else if (timer2_control_reg[B_TR2] && t2_step) begin
			t2_count <= t2_count + 16'h0001;
		end
	end

	// timer 2 control, overflow flag; set wins over software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer2_control_reg <= SCON_RST;
		end else begin
			if (wr_t2) begin
				timer2_control_reg <= wdata;
			end
			if (t2_roll && !t2_baud) begin
				timer2_control_reg[B_TF2] <= 1'b1;
			end
		end
	end

	// reload registers, baud double, prescaler
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reload_capture_low  <= 8'h00;
			reload_capture_high <= 8'h00;
			baud_double_select  <= 2'h0;
			m2_div              <= 6'h00;
			t2_half             <= 1'b0;
		end else begin
			m2_div  <= m2_div + 6'h01;
			t2_half <= !t2_half;
			if (wr && addr == ADDR_RCAPL) reload_capture_low <= wdata;
			if (wr && addr == ADDR_RCAPH) reload_capture_high <= wdata;
			if (wr && addr == ADDR_MISC) baud_double_select <= wdata[1:0];
		end
	end

	// read data, one cycle after strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				ADDR_SCON0: rdata <= scon_rd[0];
				ADDR_SERIAL_BUFFER_PORT0: rdata <= sbuf_rd[0];
				ADDR_SCON1: rdata <= scon_rd[1];
				ADDR_SERIAL_BUFFER_PORT1: rdata <= sbuf_rd[1];
				ADDR_T2CTL: rdata <= timer2_control_reg;
				ADDR_RCAPL: rdata <= reload_capture_low;
				ADDR_RCAPH: rdata <= reload_capture_high;
				ADDR_MISC:  rdata <= {6'h00, baud_double_select};
				default:    rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// two identical ports; only port 0 sees timer 2
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			logic [7:0]  ctl;          // mode, mpe, ren, tb8, rb8, ti, ri
			logic [7:0]  rbuf;         // received byte
			logic [8:0]  tsh;          // tx shift: data + ninth
			asp_state_t  tst;          // tx state
			asp_state_t  rst_st;       // rx state
			logic [3:0]  tdiv;         // tx divide-by-16
			logic [3:0]  rdiv;         // rx divide-by-16
			logic [3:0]  tbit;         // tx bit index
			logic [3:0]  rbit;         // rx bit index
			logic [1:0]  tdly;         // mode 1 done delay
			logic [1:0]  smp;          // first two mid-bit samples
			logic [8:0]  rsh;          // rx data + ninth
			logic        rx_q;         // previous rx level
			logic        txo;          // tx pin level

			wire rx_in  = (p == 0) ? receive_pin_port0 : receive_pin_port1;
			wire [1:0] mode = ctl[B_MODE_HI -: 2];
			wire m23    = mode[1];
			wire a_scon = wr && (addr == ((p == 0) ? ADDR_SCON0 : ADDR_SCON1));
			wire a_sbuf = wr && (addr == ((p == 0) ? ADDR_SERIAL_BUFFER_PORT0 : ADDR_SERIAL_BUFFER_PORT1));
			wire tmr_t  = (p == 0 && tx_baud_from_timer2) ? t2_roll : timer1_overflow;
			wire tmr_r  = (p == 0 && rclk) ? t2_roll : timer1_overflow;
			wire m2tk   = baud_double_select[p] ? m2_tick_half : m2_tick_full;
			wire tick_t = (mode == 2'b10) ? m2tk : tmr_t;
			wire tick_r = (mode == 2'b10) ? m2tk : tmr_r;
			wire troll  = tick_t && (tdiv == DIV16_LAST);
			wire [3:0] last_bit = m23 ? BITS_M23 : BITS_M1;
			// third sample is the live pin at the last sampling tick
			wire vote   = (smp[0] & smp[1]) | (smp[1] & rx_in) | (smp[0] & rx_in);
			wire samp_end = tick_r && (rdiv == SAMP_C);
			wire [8:0] rnext = {vote, rsh[8:1]};
			wire stop_ok  = !ctl[B_RI] && (!ctl[B_MPE] || (m23 ? rsh[8] : vote));
			wire accept   = samp_end && rst_st == ST_SHIFT && rbit == last_bit && stop_ok;
			wire ti_set   = (m23 && tst == ST_SHIFT && troll && tbit == last_bit - 4'h1)
			                || (tdly == 2'h1);

			assign scon_rd[p] = ctl;
			assign sbuf_rd[p] = rbuf;

			// transmitter: wait for rollover, then shift frame
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					tst  <= ST_IDLE;
					tdiv <= 4'h0;
					tbit <= 4'h0;
					tsh  <= 9'h1ff;
					txo  <= 1'b1;
					tdly <= 2'h0;
				end else begin
					if (tick_t) tdiv <= tdiv + 4'h1;
					if (tdly != 2'h0) tdly <= tdly - 2'h1;
					case (tst)
						ST_IDLE: begin
							if (a_sbuf) begin
								tsh <= {(m23 ? ctl[B_TB8] : 1'b1), wdata};
								tst <= ST_WAIT;
							end
						end
						ST_WAIT: begin
							if (troll) begin
								txo  <= 1'b0;
								tbit <= 4'h0;
								tst  <= ST_SHIFT;
							end
						end
						ST_SHIFT: begin
							if (troll) begin
								if (tbit == last_bit) begin
									tst <= ST_DONE;
									if (!m23) tdly <= TI_DELAY;
								end else begin
									txo  <= (tbit == last_bit - 4'h1) ? 1'b1 : tsh[0];
									tsh  <= {1'b1, tsh[8:1]};
									tbit <= tbit + 4'h1;
								end
							end
						end
						ST_DONE: begin
							tst <= ST_IDLE;
						end
						default: tst <= ST_IDLE;
					endcase
				end
			end

			// receiver: edge detect, 16x sampling, vote, accept
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					rst_st <= ST_IDLE;
					rdiv   <= 4'h0;
					rbit   <= 4'h0;
					smp    <= 2'h3;
					rsh    <= 9'h000;
					rx_q   <= 1'b1;
				end else begin
					rx_q <= rx_in;
					if (tick_r) rdiv <= rdiv + 4'h1;
					if (tick_r && rdiv >= SAMP_A && rdiv <= SAMP_C) smp <= {rx_in, smp[1]};
					case (rst_st)
						ST_IDLE: begin
							if (ctl[B_REN] && rx_q && !rx_in) begin
								rdiv   <= 4'h0;
								rbit   <= 4'h0;
								rst_st <= ST_SHIFT;
							end
						end
						ST_SHIFT: begin
							if (samp_end) begin
								if (rbit == 4'h0 && vote) begin
									rst_st <= ST_IDLE;
								end else if (rbit == last_bit) begin
									rst_st <= ST_IDLE;
								end else begin
									rsh  <= rnext;
									rbit <= rbit + 4'h1;
								end
							end
						end
						default: rst_st <= ST_IDLE;
					endcase
				end
			end

			// control register, buffer; hardware set wins over clear
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					ctl  <= SCON_RST;
					rbuf <= 8'h00;
				end else begin
					if (a_scon) ctl <= wdata;
					if (ti_set) ctl[B_TI] <= 1'b1;
					if (accept) begin
						rbuf       <= m23 ? rsh[7:0] : rsh[8:1];
						ctl[B_RB8] <= vote && !m23 || (m23 && rsh[8]);
						ctl[B_RI]  <= 1'b1;
					end
				end
			end
		end
	endgenerate

	assign transmit_pin_port0 = g_port[0].txo;
	assign transmit_pin_port1 = g_port[1].txo;
endmodule : asp_top
`default_nettype wire

// *** asp_chk.sv ***
// asp_chk: port-level assertions for the serial port pair
// assumes it is bound into asp_top and sees only its ports
`default_nettype none
module asp_chk
	import asp_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       transmit_pin_port0,
	input wire logic       transmit_pin_port1
);
	logic sent0; // port 0 buffer written since reset
	logic sent1; // port 1 buffer written since reset
	logic ren0;  // port 0 receiver ever enabled

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// sticky history of software writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sent0 <= 1'b0;
			sent1 <= 1'b0;
			ren0  <= 1'b0;
		end else begin
			sent0 <= sent0 | (wr & (addr == ADDR_SERIAL_BUFFER_PORT0));
			sent1 <= sent1 | (wr & (addr == ADDR_SERIAL_BUFFER_PORT1));
			ren0  <= ren0 | (wr & (addr == ADDR_SCON0) & wdata[B_REN]);
		end
	end

	rdata_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read answer");
	unmapped_zero_a: assert property ($past(rd) && $past(addr) > ADDR_MISC |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	tf2_blocked_a: assert property ($past(rd) && $past(addr) == ADDR_T2CTL && (rdata[B_TX_BAUD_FROM_TIMER2] || rdata[B_RCLK])
		|-> !rdata[B_TF2]) else $error("overflow flag set during baud use");
	idle_tx0_a: assert property (!sent0 |-> transmit_pin_port0)
		else $error("port 0 sends without buffer write");
	idle_tx1_a: assert property (!sent1 |-> transmit_pin_port1)
		else $error("port 1 sends without buffer write");
	bit_hold0_a: assert property ($changed(transmit_pin_port0) |=> $stable(transmit_pin_port0) [*8])
		else $error("port 0 bit too short");
	bit_hold1_a: assert property ($changed(transmit_pin_port1) |=> $stable(transmit_pin_port1) [*8])
		else $error("port 1 bit too short");
	ri_needs_ren_a: assert property ($past(rd) && $past(addr) == ADDR_SCON0 && !ren0 |-> !rdata[B_RI])
		else $error("receive flag without receive enable");

	cover property ($fell(transmit_pin_port0));
	cover property ($fell(transmit_pin_port1));
	cover property ($past(rd) && $past(addr) == ADDR_SCON1 && rdata[B_RI]);
endmodule : asp_chk

bind asp_top asp_chk i_asp_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .transmit_pin_port0(transmit_pin_port0), .transmit_pin_port1(transmit_pin_port1));
`default_nettype wire

// *** asp_peer.sv ***
// asp_peer: remote serial peer on both ports
// assumes pins synchronous to clk, idle high; bit times given in clocks
`default_nettype none
module asp_peer (
	input  wire logic       clk,     // core clock
	input  wire logic [1:0] tx_line, // device transmit pins
	output var  logic [1:0] rx_line  // device receive pins
);
	timeunit 1ns;
	timeprecision 1ns;

	initial rx_line = 2'b11; // idle high

	// start bit, then n bits lsb first, then idle high
	task automatic send(input int p, input logic [9:0] f, input int n, input int cyc);
		rx_line[p] <= 1'b0;
		repeat (cyc) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rx_line[p] <= f[i];
			repeat (cyc) @(posedge clk);
		end
		rx_line[p] <= 1'b1;
	endtask : send

	// wait for a start edge, then sample n bits at mid-bit
	task automatic get(input int p, input int n, input int cyc, output logic [9:0] f);
		int w;
		f = 10'h000;
		w = 0;
		while (tx_line[p] !== 1'b0 && w < 5000) begin
			@(posedge clk);
			w++;
		end
		repeat (cyc / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (cyc) @(posedge clk);
			f[i] = tx_line[p];
		end
	endtask : get
endmodule : asp_peer
`default_nettype wire

// *** asp_top_test.sv ***
// asp_top_test: register tests of both serial ports against a peer
// assumes asp_peer on the pins and asp_chk bound into asp_top
`default_nettype none
module asp_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import asp_pkg::*;

	localparam logic [15:0] RELOAD = 16'hfffe;                // timer 2 reload
	localparam int          BIT1   = 32 * (65536 - int'(RELOAD)); // clocks per bit, timer 2
	localparam int          BIT2   = 64;                        // clocks per bit, mode 2
	localparam int          LIMIT  = 20000;                     // hang ceiling
	logic       clk   = 1'b0;
	logic       rst_b = 1'b0;
	logic [3:0] addr  = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic       trig  = 1'b0;
	logic [7:0] rdata;
	logic [1:0] txp;
	logic [1:0] rxp;
	logic [9:0] f;
	int         bad_count  = 0;
	int         n_compared = 0;
	int         cyc        = 0;

	asp_top i_asp_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.timer1_overflow(1'b0), .timer2_external_reload_trigger(trig), .receive_pin_port0(rxp[0]),
		.receive_pin_port1(rxp[1]), .transmit_pin_port0(txp[0]), .transmit_pin_port1(txp[1]));
	asp_peer i_asp_peer (.clk(clk), .tx_line(txp), .rx_line(rxp));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
		n_compared++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, {2'b00, e}, {2'b00, rdata});
	endtask : rd_chk

	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(ADDR_SCON0, 8'h00, "scon0 reset");
		rd_chk(ADDR_T2CTL, 8'h00, "t2ctl reset");
		wr_reg(4'hf, 8'hff);
		rd_chk(4'hf, 8'h00, "unmapped");
		// port 0 mode 1, both directions on timer 2
		wr_reg(ADDR_RCAPL, RELOAD[7:0]);
		wr_reg(ADDR_RCAPH, RELOAD[15:8]);
		wr_reg(ADDR_T2CTL, 8'h34);
		trig <= 1'b1;
		wr_reg(ADDR_SCON0, 8'h50);
		wr_reg(ADDR_SERIAL_BUFFER_PORT0, 8'h3c);
		fork
			i_asp_peer.get(0, 9, BIT1, f);
			i_asp_peer.send(0, 10'h1c3, 9, BIT1);
		join
		chk("tx0 frame", 10'h13c, f);
		repeat (2 * BIT1) @(posedge clk);
		rd_chk(ADDR_SCON0, 8'h57, "scon0 flags");
		rd_chk(ADDR_SERIAL_BUFFER_PORT0, 8'hc3, "serial_buffer_port0 rx");
		rd_chk(ADDR_T2CTL, 8'h34, "t2ctl flag");
		i_asp_peer.send(0, 10'h111, 9, BIT1);
		rd_chk(ADDR_SERIAL_BUFFER_PORT0, 8'hc3, "serial_buffer_port0 kept");
		wr_reg(ADDR_SCON0, 8'h50);
		i_asp_peer.send(0, 10'h3ff, 0, 8);
		repeat (BIT1) @(posedge clk);
		i_asp_peer.send(0, 10'h1a7, 9, BIT1);
		rd_chk(ADDR_SCON0, 8'h55, "scon0 after glitch");
		rd_chk(ADDR_SERIAL_BUFFER_PORT0, 8'ha7, "serial_buffer_port0 after glitch");
		wr_reg(ADDR_SCON0, 8'h40);
		i_asp_peer.send(0, 10'h155, 9, BIT1);
		rd_chk(ADDR_SCON0, 8'h40, "receiver off");
		// port 1 mode 2 with multiprocessor filter
		wr_reg(ADDR_SCON1, 8'hb8);
		wr_reg(ADDR_SERIAL_BUFFER_PORT1, 8'ha5);
		fork
			i_asp_peer.get(1, 10, BIT2, f);
			i_asp_peer.send(1, 10'h25a, 10, BIT2);
		join
		chk("tx1 frame", 10'h3a5, f);
		rd_chk(ADDR_SCON1, 8'hba, "ninth zero");
		wr_reg(ADDR_MISC, 8'h02);
		i_asp_peer.send(1, 10'h35a, 10, BIT2 / 2);
		rd_chk(ADDR_SCON1, 8'hbf, "ninth one");
		rd_chk(ADDR_SERIAL_BUFFER_PORT1, 8'h5a, "serial_buffer_port1 rx");
		print_verdict();
	end
endmodule : asp_top_test
`default_nettype wire
